/* verilog/timer16_pkg.sv */
// Constants for the 16-bit timer with input capture.
// Assumes an 8-bit register port driven by a processor core on clock_in.
// Function
// - High-byte writes and count/capture high reads use shared holding register.
// - Low-byte read latches counter high into holding.
// - Low-byte write loads holding and byte together.
// - Clock select picks tick; zero stops counter.
// - Counter accessible whether ticks arrive or not.
// - Processor write beats clear and count.
// - Each tick clears, increments or decrements counter.
// - Overflow flag set where mode defines; interrupts.
// - Selected edge copies counter into capture register.
// - Capture flag set in the copy cycle.
// - Enabled flag interrupts; cleared by service or one.
// - Capture low read latches high into holding.
// - Capture writable only in capture-top modes.
// - Comparator select switches trigger; clear flag after.
// - Filter changes after four equal samples.
// - Filter adds four system clocks of delay.
// - Capture input off in capture-top modes.
// - Every capture overwrites the capture register.
// - Port-driven pin captures like external edge.
// - One holding register; write high before low.
// - Top is fixed, compare A or capture.
package timer16_pkg;

    // Register locations on the 8-bit port
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h01;
    localparam logic [7:0] ADDR_FLAGS = 8'h02;
    localparam logic [7:0] ADDR_MASK = 8'h03;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h05;
    localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h06;
    localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h07;
    localparam logic [7:0] ADDR_COMPARE_A_LOW = 8'h08;
    localparam logic [7:0] ADDR_COMPARE_A_HIGH = 8'h09;

    // Field positions
    localparam int CTRL_A_MODE_LSB = 0;
    localparam int CTRL_B_CLOCK_LSB = 0;
    localparam int CTRL_B_MODE_LSB = 3;
    localparam int CTRL_B_EDGE_BIT = 6;
    localparam int CTRL_B_FILTER_BIT = 7;
    localparam int FLAG_OVERFLOW_BIT = 0;
    localparam int FLAG_CAPTURE_BIT = 5;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Clock select codes
    localparam logic [2:0] CLOCK_NONE = 3'h0;
    localparam logic [2:0] CLOCK_DIV1 = 3'h1;
    localparam logic [2:0] CLOCK_DIV8 = 3'h2;
    localparam logic [2:0] CLOCK_DIV64 = 3'h3;
    localparam logic [2:0] CLOCK_DIV256 = 3'h4;
    localparam logic [2:0] CLOCK_DIV1024 = 3'h5;
    localparam logic [2:0] CLOCK_EXT_FALL = 3'h6;
    localparam logic [2:0] CLOCK_EXT_RISE = 3'h7;

    // Prescaler terminal masks
    localparam int PRESCALE_WIDTH = 10;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

    // Fixed top values
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // Count sequence kinds
    typedef enum logic [1:0] {
        SEQ_NORMAL = 2'h0,
        SEQ_CLEAR = 2'h1,
        SEQ_FAST = 2'h2,
        SEQ_DUAL = 2'h3
    } seq_kind_t;

    // Count direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;

    // Filter depth in system clocks
    localparam int FILTER_SAMPLES = 4;

endpackage

/* verilog/capture_conditioner.sv */
// Synchroniser and optional majority-free noise filter for the capture input.
// Assumes raw_in is asynchronous to clock_in.
`timescale 1ns/1ns
module capture_conditioner #(
    parameter int SAMPLES = timer16_pkg::FILTER_SAMPLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Signal
    input wire logic raw_in,
    input wire logic filter_enable_in,
    output logic level_out
);
    import timer16_pkg::*;

    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic stable_q;
    logic stable_d;
    logic [SAMPLES-1:0] hist_q;
    logic [SAMPLES-1:0] hist_d;
    logic level_q;
    logic level_d;

    always_comb begin
        sync_d = {sync_q[1:0], raw_in};
        stable_d = stable_q;
        // Only the second and third stages are compared
        if (sync_q[1] == sync_q[2]) begin
            stable_d = sync_q[2];
        end
        hist_d = {hist_q[SAMPLES-2:0], stable_q};
        level_d = level_q;
        if (!filter_enable_in) begin
            level_d = stable_q;
        end else if (&hist_q || ~|hist_q) begin
            level_d = hist_q[0];
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_q <= 3'h0;
            stable_q <= 1'b0;
            hist_q <= '0;
            level_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            stable_q <= stable_d;
            hist_q <= hist_d;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;

endmodule

/* verilog/timer16_capture.sv */
// 16-bit timer/counter with input capture on an 8-bit register port.
// Assumes a processor core issuing single-cycle read and write strobes.
`timescale 1ns/1ns
module timer16_capture (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // Pins and neighbour signals
    input wire logic capture_pin_in,
    input wire logic comparator_output_in,
    input wire logic comparator_capture_select_in,
    input wire logic external_count_pin_in,
    // Interrupts
    input wire logic capture_irq_ack_in,
    input wire logic overflow_irq_ack_in,
    output logic capture_irq_out,
    output logic overflow_irq_out
);
    import timer16_pkg::*;

    logic [1:0] ctrl_a_q;
    logic [1:0] ctrl_a_d;
    logic [7:0] ctrl_b_q;
    logic [7:0] ctrl_b_d;
    logic [7:0] hold_q;
    logic [7:0] hold_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] capture_q;
    logic [15:0] capture_d;
    logic [15:0] compare_a_q;
    logic [15:0] compare_a_d;
    dir_t dir_q;
    dir_t dir_d;
    logic cap_flag_q;
    logic cap_flag_d;
    logic ov_flag_q;
    logic ov_flag_d;
    logic cap_en_q;
    logic cap_en_d;
    logic ov_en_q;
    logic ov_en_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic cap_irq_q;
    logic ov_irq_q;
    logic [9:0] presc_q;
    logic [9:0] presc_d;
    logic [2:0] ext_sync_q;
    logic [2:0] ext_sync_d;
    logic ext_level_q;
    logic ext_level_d;
    logic edge_prev_q;
    logic edge_prev_d;

    logic [3:0] mode;
    logic [2:0] clock_sel;
    logic [15:0] top;
    logic [15:0] fixed_top;
    seq_kind_t kind;
    logic capture_top;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic cap_raw;
    logic cap_level;
    logic cap_event;
    logic ov_set;
    logic wr_count;
    logic wr_capture;
    logic wr_high;

    assign mode = {ctrl_b_q[CTRL_B_MODE_LSB+1:CTRL_B_MODE_LSB],
                   ctrl_a_q};
    assign clock_sel = ctrl_b_q[CTRL_B_CLOCK_LSB+2:CTRL_B_CLOCK_LSB];
    assign fixed_top = (mode[1:0] == 2'h1) ? TOP_8BIT
                     : (mode[1:0] == 2'h2) ? TOP_9BIT : TOP_10BIT;

    // Mode decode: sequence kind and top source
    always_comb begin
        kind = SEQ_NORMAL;
        top = COUNT_MAX;
        capture_top = 1'b0;
        case (mode)
            4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: begin
                kind = mode[2] ? SEQ_FAST : SEQ_DUAL;
                top = fixed_top;
            end
            4'h4: begin
                kind = SEQ_CLEAR;
                top = compare_a_q;
            end
            4'h8, 4'hA: begin
                kind = SEQ_DUAL;
                top = capture_q;
                capture_top = 1'b1;
            end
            4'h9, 4'hB: begin
                kind = SEQ_DUAL;
                top = compare_a_q;
            end
            4'hC: begin
                kind = SEQ_CLEAR;
                top = capture_q;
                capture_top = 1'b1;
            end
            4'hE: begin
                kind = SEQ_FAST;
                top = capture_q;
                capture_top = 1'b1;
            end
            4'hF: begin
                kind = SEQ_FAST;
                top = compare_a_q;
            end
            default: begin
                // Mode 0 and reserved 13: plain sequence
                kind = SEQ_NORMAL;
            end
        endcase
    end

    // Tick source: prescaler taps or synchronised count pin
    always_comb begin
        presc_d = (clock_sel == CLOCK_NONE) ? presc_q
                : presc_q + 10'h001;
        ext_sync_d = {ext_sync_q[1:0], external_count_pin_in};
        ext_level_d = ext_level_q;
        if (ext_sync_q[1] == ext_sync_q[2]) begin
            ext_level_d = ext_sync_q[2];
        end
        ext_rise = ext_level_d & ~ext_level_q;
        ext_fall = ~ext_level_d & ext_level_q;
        case (clock_sel)
            CLOCK_NONE: tick = 1'b0;
            CLOCK_DIV1: tick = 1'b1;
            CLOCK_DIV8: tick = (presc_q & MASK_DIV8) == MASK_DIV8;
            CLOCK_DIV64: tick = (presc_q & MASK_DIV64) == MASK_DIV64;
            CLOCK_DIV256: tick = (presc_q & MASK_DIV256) == MASK_DIV256;
            CLOCK_DIV1024: tick = presc_q == MASK_DIV1024;
            CLOCK_EXT_FALL: tick = ext_fall;
            CLOCK_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // Capture trigger path; the pin is read back whoever drives it
    assign cap_raw = comparator_capture_select_in ?
                     comparator_output_in : capture_pin_in;

    capture_conditioner #(
        .SAMPLES(FILTER_SAMPLES)
    ) u_conditioner (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .raw_in(cap_raw),
        .filter_enable_in(ctrl_b_q[CTRL_B_FILTER_BIT]),
        .level_out(cap_level)
    );

    always_comb begin
        edge_prev_d = cap_level;
        cap_event = 1'b0;
        if (!capture_top) begin
            cap_event = ctrl_b_q[CTRL_B_EDGE_BIT] ?
                        (cap_level & ~edge_prev_q) :
                        (~cap_level & edge_prev_q);
        end
    end

    // Bus decode
    assign wr_count = wr_in && (addr_in == ADDR_COUNT_LOW);
    assign wr_capture = wr_in && (addr_in == ADDR_CAPTURE_LOW);
    assign wr_high = wr_in && (addr_in == ADDR_COUNT_HIGH ||
                               addr_in == ADDR_CAPTURE_HIGH ||
                               addr_in == ADDR_COMPARE_A_HIGH);

    // Counter and direction
    always_comb begin
        count_d = count_q;
        dir_d = dir_q;
        ov_set = 1'b0;
        if (tick) begin
            case (kind)
                SEQ_NORMAL: begin
                    count_d = count_q + COUNT_ONE;
                    ov_set = count_q == COUNT_MAX;
                end
                SEQ_CLEAR: begin
                    count_d = (count_q == top) ? COUNT_BOTTOM
                            : count_q + COUNT_ONE;
                    ov_set = count_q == COUNT_MAX;
                end
                SEQ_FAST: begin
                    count_d = (count_q == top) ? COUNT_BOTTOM
                            : count_q + COUNT_ONE;
                    ov_set = count_q == top;
                end
                SEQ_DUAL: begin
                    if (dir_q == DIR_UP) begin
                        if (count_q >= top) begin
                            dir_d = DIR_DOWN;
                            count_d = count_q - COUNT_ONE;
                        end else begin
                            count_d = count_q + COUNT_ONE;
                        end
                    end else if (count_q == COUNT_BOTTOM) begin
                        dir_d = DIR_UP;
                        count_d = COUNT_ONE;
                    end else begin
                        count_d = count_q - COUNT_ONE;
                        if (count_q == COUNT_ONE) begin
                            dir_d = DIR_UP;
                            ov_set = 1'b1;
                        end
                    end
                end
                default: count_d = count_q;
            endcase
        end
        if (wr_count) begin
            count_d = {hold_q, wdata_in};
        end
    end

    // Holding byte, capture and compare registers
    always_comb begin
        hold_d = hold_q;
        capture_d = capture_q;
        compare_a_d = compare_a_q;
        if (wr_high) begin
            hold_d = wdata_in;
        end else if (rd_in && addr_in == ADDR_COUNT_LOW) begin
            hold_d = count_q[15:8];
        end else if (rd_in && addr_in == ADDR_CAPTURE_LOW) begin
            hold_d = capture_q[15:8];
        end
        if (cap_event) begin
            capture_d = count_q;
        end
        if (wr_capture && capture_top) begin
            capture_d = {hold_q, wdata_in};
        end
        if (wr_in && addr_in == ADDR_COMPARE_A_LOW) begin
            compare_a_d = {hold_q, wdata_in};
        end
    end

    // Control, flags and mask; a new event beats a clear
    always_comb begin
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        cap_en_d = cap_en_q;
        ov_en_d = ov_en_q;
        cap_flag_d = cap_flag_q;
        ov_flag_d = ov_flag_q;
        if (wr_in && addr_in == ADDR_CTRL_A) begin
            ctrl_a_d = wdata_in[CTRL_A_MODE_LSB+1:CTRL_A_MODE_LSB];
        end
        if (wr_in && addr_in == ADDR_CTRL_B) begin
            // Bit 5 is reserved and reads as zero
            ctrl_b_d = wdata_in & 8'hDF;
        end
        if (wr_in && addr_in == ADDR_MASK) begin
            cap_en_d = wdata_in[FLAG_CAPTURE_BIT];
            ov_en_d = wdata_in[FLAG_OVERFLOW_BIT];
        end
        if (capture_irq_ack_in || (wr_in && addr_in == ADDR_FLAGS &&
                                   wdata_in[FLAG_CAPTURE_BIT])) begin
            cap_flag_d = 1'b0;
        end
        if (overflow_irq_ack_in || (wr_in && addr_in == ADDR_FLAGS &&
                                    wdata_in[FLAG_OVERFLOW_BIT])) begin
            ov_flag_d = 1'b0;
        end
        if (cap_event) begin
            cap_flag_d = 1'b1;
        end
        if (ov_set) begin
            ov_flag_d = 1'b1;
        end
    end

    // Read data, registered; unmapped locations read zero
    always_comb begin
        rdata_d = RESET_BYTE;
        if (rd_in) begin
            case (addr_in)
                ADDR_CTRL_A: rdata_d = {6'h00, ctrl_a_q};
                ADDR_CTRL_B: rdata_d = ctrl_b_q;
                ADDR_FLAGS: begin
                    rdata_d[FLAG_CAPTURE_BIT] = cap_flag_q;
                    rdata_d[FLAG_OVERFLOW_BIT] = ov_flag_q;
                end
                ADDR_MASK: begin
                    rdata_d[FLAG_CAPTURE_BIT] = cap_en_q;
                    rdata_d[FLAG_OVERFLOW_BIT] = ov_en_q;
                end
                ADDR_COUNT_LOW: rdata_d = count_q[7:0];
                ADDR_COUNT_HIGH: rdata_d = hold_q;
                ADDR_CAPTURE_LOW: rdata_d = capture_q[7:0];
                ADDR_CAPTURE_HIGH: rdata_d = hold_q;
                // Compare A never changes by itself, so no holding
                ADDR_COMPARE_A_LOW: rdata_d = compare_a_q[7:0];
                ADDR_COMPARE_A_HIGH: rdata_d = compare_a_q[15:8];
                default: rdata_d = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_a_q <= 2'h0;
            ctrl_b_q <= RESET_BYTE;
            hold_q <= RESET_BYTE;
            count_q <= RESET_WORD;
            capture_q <= RESET_WORD;
            compare_a_q <= RESET_WORD;
            dir_q <= DIR_UP;
            cap_flag_q <= 1'b0;
            ov_flag_q <= 1'b0;
            cap_en_q <= 1'b0;
            ov_en_q <= 1'b0;
            rdata_q <= RESET_BYTE;
            cap_irq_q <= 1'b0;
            ov_irq_q <= 1'b0;
            presc_q <= 10'h000;
            ext_sync_q <= 3'h0;
            ext_level_q <= 1'b0;
            edge_prev_q <= 1'b0;
        end else begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            hold_q <= hold_d;
            count_q <= count_d;
            capture_q <= capture_d;
            compare_a_q <= compare_a_d;
            dir_q <= dir_d;
            cap_flag_q <= cap_flag_d;
            ov_flag_q <= ov_flag_d;
            cap_en_q <= cap_en_d;
            ov_en_q <= ov_en_d;
            rdata_q <= rdata_d;
            cap_irq_q <= cap_flag_d & cap_en_d;
            ov_irq_q <= ov_flag_d & ov_en_d;
            presc_q <= presc_d;
            ext_sync_q <= ext_sync_d;
            ext_level_q <= ext_level_d;
            edge_prev_q <= edge_prev_d;
        end
    end

    assign rdata_out = rdata_q;
    assign capture_irq_out = cap_irq_q;
    assign overflow_irq_out = ov_irq_q;

endmodule

/* test/timer16_capture_checker.sv */
// Port assertions for the 16-bit timer with input capture.
// Assumes the single-cycle strobe register port of timer16_capture.
`timescale 1ns/1ns
module timer16_capture_checker
    import timer16_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic capture_irq_out,
    input wire logic overflow_irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    logic quiet, wr_hi, wr_lo;
    assign quiet = !wr_in && !rd_in;
    assign wr_hi = wr_in && addr_in == ADDR_COUNT_HIGH;
    assign wr_lo = wr_in && addr_in == ADDR_COUNT_LOW;
    chk_read_idle: assert property (
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    chk_unmapped_zero: assert property (
        rd_in && addr_in > ADDR_COMPARE_A_HIGH |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_shared_hold: assert property (
        wr_in && addr_in[0] && addr_in > ADDR_COUNT_LOW
        && addr_in < 8'h0A ##1 quiet ##1 rd_in
        && (addr_in == ADDR_COUNT_HIGH || addr_in == ADDR_CAPTURE_HIGH)
        |=> rdata_out == $past(wdata_in, 3))
        else $error("high byte not from shared holding byte");
    chk_count_low: assert property (
        wr_hi ##1 wr_lo ##1 rd_in && addr_in == ADDR_COUNT_LOW
        |=> rdata_out == $past(wdata_in, 2))
        else $error("count low not the written byte");
    chk_count_high: assert property (
        wr_hi ##1 wr_lo ##1 rd_in && addr_in == ADDR_COUNT_LOW
        ##1 rd_in && addr_in == ADDR_COUNT_HIGH
        |=> rdata_out == $past(wdata_in, 4))
        else $error("count high not latched by low read");
    chk_compare_word: assert property (
        wr_in && addr_in == ADDR_COMPARE_A_HIGH
        ##1 wr_in && addr_in == ADDR_COMPARE_A_LOW ##1 quiet
        ##1 rd_in && addr_in == ADDR_COMPARE_A_LOW
        |=> rdata_out == $past(wdata_in, 3))
        else $error("compare word low byte lost");
    chk_cap_mask: assert property (
        wr_in && addr_in == ADDR_MASK && !wdata_in[5]
        |-> ##2 !capture_irq_out)
        else $error("capture request with enable off");
    chk_ovf_mask: assert property (
        wr_in && addr_in == ADDR_MASK && !wdata_in[0]
        |-> ##2 !overflow_irq_out)
        else $error("overflow request with enable off");
    cover property (rd_in && addr_in == ADDR_CAPTURE_LOW);
    cover property ($rose(capture_irq_out));
    cover property ($rose(overflow_irq_out));
endmodule
bind timer16_capture timer16_capture_checker u_chk (.clock_in, .nrst_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .capture_irq_out,
    .overflow_irq_out);

/* test/cpu_model.sv */
// Processor core model on the 8-bit register port.
// Assumes every call starts at a falling edge of clock_in.
`timescale 1ns/1ns
module cpu_model (
    // Clock
    input wire logic clock_in,
    // Register port
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [7:0] rdata_in
);
    initial {addr_out, wdata_out, wr_out, rd_out} = 18'h00000;
    task put(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        rd_out = 1'b0;
        @(negedge clock_in);
    endtask
    task get(input logic [7:0] a, output logic [7:0] d);
        addr_out = a;
        wr_out = 1'b0;
        rd_out = 1'b1;
        @(negedge clock_in);
        d = rdata_in;
    endtask
    // Released lines flip so stale values never look valid
    task idle;
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
        @(negedge clock_in);
    endtask
    task w8(input logic [7:0] a, input logic [7:0] d);
        put(a, d);
        idle();
    endtask
    task r8(input logic [7:0] a, output logic [7:0] d);
        get(a, d);
        idle();
    endtask
    // No gap inside a word, so nothing can disturb the holding byte
    task w16(input logic [7:0] lo, input logic [15:0] v);
        put(lo + 8'h01, v[15:8]);
        put(lo, v[7:0]);
        idle();
    endtask
    task r16(input logic [7:0] lo, output logic [15:0] v);
        get(lo, v[7:0]);
        get(lo + 8'h01, v[15:8]);
        idle();
    endtask
    // Count write and read back, no gap
    task wr16(input logic [15:0] v, output logic [15:0] r);
        put(8'h05, v[15:8]);
        put(8'h04, v[7:0]);
        get(8'h04, r[7:0]);
        get(8'h05, r[15:8]);
        idle();
    endtask
endmodule

/* test/tb_timer16_counter_input_capture.sv */
// Self-checking bench for the 16-bit timer with input capture.
// Assumes cpu_model drives the register port; pins driven here.
`timescale 1ns/1ns
module tb_timer16_counter_input_capture;
    import timer16_pkg::*;
    logic clock_in, nrst_in, wr, rd, pin, comp, csel, ext;
    logic cap_ack, ovf_ack, cap_irq, ovf_irq;
    logic [7:0] addr, wdata, rdata, d;
    logic [15:0] v, c0, c1;
    int bad_count, compares, cycles;
    cpu_model cpu (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
    timer16_capture dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .capture_pin_in(pin),
        .comparator_output_in(comp), .comparator_capture_select_in(csel),
        .external_count_pin_in(ext), .capture_irq_ack_in(cap_ack),
        .overflow_irq_ack_in(ovf_ack), .capture_irq_out(cap_irq),
        .overflow_irq_out(ovf_irq));
    always #2 clock_in = ~clock_in;
    task end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard: the full run needs well under a thousand cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            bad_count++;
        end
    endtask
    task wait_n(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task t_reset;
        cpu.w8(8'h0A, 8'h5A);
        cpu.w8(ADDR_MASK, 8'h00);
        for (int a = 0; a < 11; a++) begin
            cpu.r8(a[7:0], d);
            chk("reset value", 16'h0000, {8'h00, d});
        end
    endtask
    task t_count;
        cpu.w16(ADDR_COUNT_LOW, 16'h01FF);
        wait_n(20);
        cpu.r16(ADDR_COUNT_LOW, v);
        chk("stopped count", 16'h01FF, v);
        cpu.w8(ADDR_CAPTURE_HIGH, 8'hAB);
        cpu.r8(ADDR_COUNT_HIGH, d);
        chk("shared hold", 16'h00AB, {8'h00, d});
        cpu.w16(ADDR_COMPARE_A_LOW, 16'h3C5A);
        cpu.r8(ADDR_COMPARE_A_LOW, d);
        chk("compare low", 16'h005A, {8'h00, d});
    endtask
    task t_run;
        cpu.w8(ADDR_CTRL_B, {5'h00, CLOCK_DIV1});
        cpu.wr16(16'h1234, v);
        chk("write beats tick", 16'h1234, v);
        cpu.w8(ADDR_CTRL_B, 8'h00);
        cpu.w8(ADDR_MASK, 8'h01);
        cpu.w8(ADDR_CTRL_A, 8'h01);
        cpu.w16(ADDR_COUNT_LOW, 16'h00FC);
        cpu.w8(ADDR_CTRL_B, {5'h01, CLOCK_DIV1});
        wait_n(12);
        cpu.w8(ADDR_CTRL_B, 8'h08);
        cpu.r16(ADDR_COUNT_LOW, v);
        chk("wrap at fixed top", 16'h1, {15'h0, v < 16'h0020});
        chk("overflow irq", 16'h1, {15'h0, ovf_irq});
        cpu.r8(ADDR_FLAGS, d);
        chk("overflow flag", 16'h0001, {8'h00, d});
        ovf_ack = 1'b1;
        wait_n(1);
        ovf_ack = 1'b0;
        wait_n(2);
        chk("overflow irq acked", 16'h0, {15'h0, ovf_irq});
        cpu.w8(ADDR_MASK, 8'h00);
        cpu.w16(ADDR_COUNT_LOW, 16'h00FE);
        cpu.w8(ADDR_CTRL_B, {5'h00, CLOCK_DIV1});
        wait_n(20);
        cpu.w8(ADDR_CTRL_B, 8'h00);
        cpu.r16(ADDR_COUNT_LOW, v);
        chk("counts down", 16'h1, {15'h0, v > 16'h00D0 && v < 16'h00FF});
        cpu.w8(ADDR_CTRL_A, 8'h00);
    endtask
    task t_ext;
        cpu.w16(ADDR_COUNT_LOW, 16'h0000);
        cpu.w8(ADDR_CTRL_B, {5'h00, CLOCK_EXT_RISE});
        repeat (5) begin
            wait_n(4);
            ext = 1'b1;
            wait_n(4);
            ext = 1'b0;
        end
        wait_n(8);
        cpu.r16(ADDR_COUNT_LOW, v);
        chk("external ticks", 16'h0005, v);
    endtask
    task cap_run(input logic filt, output logic [15:0] c);
        cpu.w8(ADDR_CTRL_B, {filt, 1'b1, 3'h0, CLOCK_DIV1});
        pin = 1'b0;
        wait_n(12);
        cpu.w8(ADDR_FLAGS, 8'h21);
        cpu.w16(ADDR_COUNT_LOW, 16'h0000);
        pin = 1'b1;
        wait_n(16);
        cpu.r16(ADDR_CAPTURE_LOW, c);
        cpu.r8(ADDR_FLAGS, d);
        chk("capture flag", 16'h0020, {8'h00, d & 8'h20});
    endtask
    task t_capture;
        cap_run(1'b0, c0);
        cap_run(1'b1, c1);
        chk("capture stamp", 16'h1, {15'h0, c0 > 0 && c0 < 16'h20});
        chk("filter delay", c0 + 16'h0004, c1);
        cpu.w8(ADDR_FLAGS, 8'h21);
        pin = 1'b0;
        wait_n(2);
        pin = 1'b1;
        wait_n(12);
        cpu.r8(ADDR_FLAGS, d);
        chk("glitch filtered", 16'h0000, {8'h00, d & 8'h20});
    endtask
    task t_comp;
        cpu.w8(ADDR_CTRL_B, 8'h00);
        cpu.w16(ADDR_COUNT_LOW, 16'h0777);
        csel = 1'b1;
        wait_n(8);
        cpu.w8(ADDR_FLAGS, 8'h20);
        cpu.w8(ADDR_MASK, 8'h20);
        comp = 1'b0;
        wait_n(8);
        chk("capture irq", 16'h1, {15'h0, cap_irq});
        cap_ack = 1'b1;
        wait_n(1);
        cap_ack = 1'b0;
        wait_n(2);
        chk("capture irq acked", 16'h0, {15'h0, cap_irq});
        cpu.w16(ADDR_COUNT_LOW, 16'h0888);
        cpu.w8(ADDR_CTRL_B, 8'h40);
        cpu.w8(ADDR_FLAGS, 8'h20);
        comp = 1'b1;
        wait_n(8);
        cpu.r16(ADDR_CAPTURE_LOW, v);
        chk("capture overwrite", 16'h0888, v);
        cpu.w8(ADDR_MASK, 8'h00);
        csel = 1'b0;
    endtask
    task t_top;
        cpu.w8(ADDR_CTRL_B, 8'h18);
        cpu.w16(ADDR_CAPTURE_LOW, 16'hBEEF);
        cpu.w8(ADDR_FLAGS, 8'h21);
        pin = 1'b0;
        wait_n(12);
        pin = 1'b1;
        wait_n(12);
        cpu.r8(ADDR_FLAGS, d);
        chk("input off at top", 16'h0000, {8'h00, d & 8'h20});
        cpu.w8(ADDR_CTRL_B, 8'h00);
        cpu.w16(ADDR_CAPTURE_LOW, 16'h1234);
        cpu.r16(ADDR_CAPTURE_LOW, v);
        chk("capture as top", 16'hBEEF, v);
    endtask
    initial begin
        clock_in = 1'b0;
        nrst_in = 1'b0;
        pin = 1'b1;
        comp = 1'b1;
        csel = 1'b0;
        ext = 1'b0;
        cap_ack = 1'b0;
        ovf_ack = 1'b0;
        bad_count = 0;
        compares = 0;
        cycles = 0;
        wait_n(8);
        nrst_in = 1'b1;
        t_reset();
        t_count();
        t_run();
        t_ext();
        t_capture();
        t_comp();
        t_top();
        end_sim();
    end
endmodule
